// >>> ccr_analog_model.sv
/* behavioural comparators and reference ladder.
   assumes supply in millivolts; outputs are asynchronous levels. */
`timescale 1ns/1ps
module ccr_analog_model #(parameter int VDD_MV = 5000) (
    // control from the block
    input wire logic       powered,
    input wire logic       internal_ref,
    input wire logic       ref_on,
    input wire logic       range_sel,
    input wire logic [3:0] tap,
    // analog stimulus
    input wire integer     ain_mv,
    input wire logic       ext1,
    input wire logic       ext2,
    // comparator outputs
    output logic           res1,
    output logic           res2
);
    int vref_mv;
    always_comb begin
        vref_mv = range_sel ? int'(tap) * VDD_MV / 24 : VDD_MV / 4 + int'(tap) * VDD_MV / 32;
        if (!ref_on) vref_mv = 0;
        res1 = powered && (internal_ref ? vref_mv > ain_mv : ext1);
        res2 = powered && (internal_ref ? vref_mv > ain_mv : ext2);
    end
endmodule

// >>> ccr_checker.sv
/* port checks for ccr_top.
   assumes it is bound into ccr_top and sees only its ports. */
`timescale 1ns/1ps
module ccr_checker (
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // analog and core side
    input wire logic        first_comparator_result,
    input wire logic        second_comparator_result,
    input wire logic [2:0]  comparator_mode_field,
    input wire logic        comparators_powered,
    input wire logic        internal_ref_to_positive,
    input wire logic        reference_power_on,
    input wire logic [3:0]  reference_tap_select,
    input wire logic        irq_request,
    input wire logic        wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       glb_en_q, per_en_q, chg_en_q;
    logic [1:0] res_q;
    logic [2:0] calm_q;
    logic       wr_setup;
    logic       en_all;
    assign wr_setup = psel && !penable && pwrite;
    assign en_all = glb_en_q && per_en_q && chg_en_q;
    // shadow the enables; count cycles the results stayed quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {glb_en_q, per_en_q, chg_en_q} <= 3'h0;
            res_q <= 2'h0;
            calm_q <= 3'h0;
        end else begin
            if (wr_setup && paddr == 12'h02c) {glb_en_q, per_en_q} <= pwdata[7:6];
            if (wr_setup && paddr == 12'h230) chg_en_q <= pwdata[6];
            res_q <= {second_comparator_result, first_comparator_result};
            if (res_q != {second_comparator_result, first_comparator_result}) calm_q <= 3'h0;
            else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
        end
    end
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in access phase");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready stood too long");
    bad_addr_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("misaligned access not refused");
    mode_off_power_a: assert property (comparator_mode_field == 3'h7 |-> !comparators_powered)
        else $error("comparators powered in off mode");
    internal_route_a: assert property (internal_ref_to_positive == (comparator_mode_field == 3'h2))
        else $error("reference routing wrong");
    unimpl_zero_a: assert property (pready && !pwrite && (paddr == 12'h07c || paddr == 12'h27c)
        |-> prdata[31:8] == 24'h0 && !prdata[4] && (paddr[9] || !prdata[5])) else $error("bit not zero");
    ref_follow_a: assert property (wr_setup && paddr == 12'h27c |-> ##2
        reference_power_on == $past(pwdata[7], 2) && reference_tap_select == $past(pwdata[3:0], 2))
        else $error("reference outputs did not follow");
    irq_gated_a: assert property (irq_request |-> $past(en_all))
        else $error("request without all enables");
    wake_enabled_a: assert property (wake_request |-> $past(chg_en_q))
        else $error("wake without change enable");
    result_bits_a: assert property (pready && !pwrite && paddr == 12'h07c && calm_q == 3'h7
        |-> prdata[7:6] == res_q) else $error("result bits wrong");
endmodule
bind ccr_top ccr_checker i_ccr_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_comparator_result(first_comparator_result),
    .second_comparator_result(second_comparator_result),
    .comparator_mode_field(comparator_mode_field), .comparators_powered(comparators_powered),
    .internal_ref_to_positive(internal_ref_to_positive),
    .reference_power_on(reference_power_on), .reference_tap_select(reference_tap_select),
    .irq_request(irq_request), .wake_request(wake_request));

// >>> ccr_pkg.sv
/*
 * ccr_pkg: register offsets, field positions, reset values and mode codes
 * for the comparator change flag and reference control block.
 * Assumes a 32-bit APB slave where each register takes one aligned word.
 */
package ccr_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_INTERRUPT_CONTROL   = 8'h0b;
    localparam logic [7:0]  IDX_PERIPHERAL_FLAGS    = 8'h0c;
    localparam logic [7:0]  IDX_COMPARATOR_CONTROL  = 8'h1f;
    localparam logic [7:0]  IDX_PORT_A_DIRECTION    = 8'h85;
    localparam logic [7:0]  IDX_PERIPHERAL_ENABLES  = 8'h8c;
    localparam logic [7:0]  IDX_REFERENCE_CONTROL   = 8'h9f;
    localparam logic [7:0]  IDX_SLEEP_CONTROL       = 8'hc0;

    // field positions
    localparam int          BIT_SECOND_RESULT       = 7;
    localparam int          BIT_FIRST_RESULT        = 6;
    localparam int          BIT_INPUT_SWITCH        = 3;
    localparam int          BIT_CHANGE_FLAG         = 6;
    localparam int          BIT_CHANGE_IRQ_ENABLE   = 6;
    localparam int          BIT_GLOBAL_IRQ_ENABLE   = 7;
    localparam int          BIT_PERIPH_IRQ_ENABLE   = 6;
    localparam int          BIT_REF_POWER_ON        = 7;
    localparam int          BIT_REF_PIN_DRIVE       = 6;
    localparam int          BIT_REF_RANGE           = 5;

    // writable masks (unimplemented bits read as zero)
    localparam logic [7:0]  MASK_COMPARATOR_WR      = 8'h0f;
    localparam logic [7:0]  MASK_REFERENCE_WR       = 8'hef;
    localparam logic [7:0]  MASK_PORT_A_WR          = 8'h1f;
    localparam logic [7:0]  MASK_INTERRUPT_WR       = 8'hfe;

    // reset values
    localparam logic [7:0]  RST_INTERRUPT_CONTROL   = 8'h00;
    localparam logic [3:0]  RST_COMPARATOR_CONTROL  = 4'h0;
    localparam logic [7:0]  RST_PORT_A_DIRECTION    = 8'h1f;
    localparam logic [7:0]  RST_REFERENCE_CONTROL   = 8'h00;

    // comparator mode field codes
    typedef enum logic [2:0] {
        CCR_MODE_RESET    = 3'h0,
        CCR_MODE_INTERNAL = 3'h2,
        CCR_MODE_OFF      = 3'h7
    } ccr_mode_t;
endpackage

// >>> ccr_top.sv
/*
 * ccr_top: digital control for two analog comparators and a 16-tap
 * reference ladder. Holds the comparator control, flag, enable, interrupt
 * control, port direction and reference control registers, detects result
 * changes and drives the interrupt request and the wake request.
 * Assumes: APB master on pclk, comparator outputs asynchronous to pclk,
 * the core sleep state written over APB to sleep control bit 0.
 */
// Contract
// RULE1 - set change flag whenever either synchronised result differs from latched value
// RULE2 - results readable at comparator control bits 7 and 6
// RULE3 - change flag at flag bit 6; write 0 clears, write 1 sets
// RULE4 - request only when change enable, peripheral enable and global enable set
// RULE5 - any read or write of comparator control relatches current results
// RULE6 - mismatch keeps setting the flag until relatched
// RULE7 - software relatches comparator control before clearing the flag
// RULE8 - a change coinciding with the control read may leave flag unset
// RULE9 - comparators stay active in sleep; enabled change interrupt wakes core
// RULE10 - mode 111 powers both comparators off
// RULE11 - waking from sleep leaves comparator control unchanged
// RULE12 - reset gives mode 000, analog inputs, comparators off during reset
// RULE13 - reference power bit 7 powers ladder; clear means powered down
// RULE14 - four-bit tap select picks one of 16 levels per range
// RULE15 - range 1 gives tap/24 of supply; range 0 quarter plus tap/32
// RULE16 - reference bit 4 and comparator bits 5,4 read zero
// RULE17 - reset clears reference power, pin drive, range and tap
// RULE18 - mode 010 routes internal reference to both positive inputs
// RULE19 - result bits are read only; writes ignored
// RULE20 - comparator outputs synchronised before mismatch detection
`timescale 1ns/1ps
module ccr_top
    import ccr_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator side
    input  wire logic        first_comparator_result,
    input  wire logic        second_comparator_result,
    output logic      [2:0]  comparator_mode_field,
    output logic             input_switch_select,
    output logic             comparators_powered,
    output logic             internal_ref_to_positive,
    // reference ladder side
    output logic             reference_power_on,
    output logic             reference_pin_drive,
    output logic             reference_range_select,
    output logic      [3:0]  reference_tap_select,
    output logic      [4:0]  port_a_direction,
    // core side
    output logic             irq_request,
    output logic             wake_request
);

    // whole state of the block
    typedef struct packed {
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  latched;
        logic        change_flag;
        logic        change_irq_enable;
        logic [6:0]  irq_ctrl;      // bits 7..1 of interrupt control
        logic [3:0]  cmp_ctrl;      // input switch and mode field
        logic [4:0]  porta_dir;
        logic [7:0]  ref_ctrl;
        logic        sleeping;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
        logic        wake;
        logic        powered;       // low in mode 111 and in reset
        logic        int_ref;       // internal reference on positive inputs
    } ccr_state_t;

    ccr_state_t s_q;
    ccr_state_t s_d;

    logic [7:0]  reg_idx;
    logic        addr_ok;
    logic        setup;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic        cmp_access;
    logic        mismatch;
    logic        irq_cond;

    // address decode: word aligned index within range
    assign reg_idx  = paddr[9:2];
    assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign setup    = psel && !penable;
    assign wbyte    = pwdata[7:0];

    // read mux, unimplemented bits zero
    always_comb begin
        rbyte = 8'h00;
        unique case (reg_idx)
            IDX_INTERRUPT_CONTROL: begin
                rbyte = {s_q.irq_ctrl, 1'b0};
            end
            IDX_PERIPHERAL_FLAGS: begin
                rbyte[BIT_CHANGE_FLAG] = s_q.change_flag;
            end
            IDX_COMPARATOR_CONTROL: begin
                // RULE2 results readable
                // RULE16 bits 5,4 zero
                rbyte = {s_q.sync2[1], s_q.sync2[0], 2'h0, s_q.cmp_ctrl};
            end
            IDX_PORT_A_DIRECTION: begin
                rbyte = {3'h0, s_q.porta_dir};
            end
            IDX_PERIPHERAL_ENABLES: begin
                rbyte[BIT_CHANGE_IRQ_ENABLE] = s_q.change_irq_enable;
            end
            IDX_REFERENCE_CONTROL: begin
                // RULE16 bit 4 zero
                rbyte = s_q.ref_ctrl & MASK_REFERENCE_WR;
            end
            IDX_SLEEP_CONTROL: begin
                rbyte[0] = s_q.sleeping;
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase
    end

    // any access to comparator control, decoded in its setup cycle
    assign cmp_access = setup && addr_ok && (reg_idx == IDX_COMPARATOR_CONTROL);

    // RULE20 compare only synchronised results
    // RULE1 mismatch against latched value
    assign mismatch = (s_q.sync2 != s_q.latched);

    // RULE4 three enables gate request
    assign irq_cond = s_q.change_flag && s_q.change_irq_enable
                      && s_q.irq_ctrl[BIT_PERIPH_IRQ_ENABLE - 1]
                      && s_q.irq_ctrl[BIT_GLOBAL_IRQ_ENABLE - 1];

    // next state
    always_comb begin
        s_d = s_q;
        // two-stage synchroniser for the comparator outputs
        s_d.sync1 = {second_comparator_result, first_comparator_result};
        s_d.sync2 = s_q.sync1;
        s_d.ready  = 1'b0;
        s_d.slverr = 1'b0;
        // zero-wait-state apb answer: data prepared in setup
        if (setup) begin
            s_d.ready  = 1'b1;
            s_d.slverr = !addr_ok;
            s_d.rdata  = (addr_ok && !pwrite) ? {24'h0, rbyte} : 32'h0;
            if (addr_ok && pwrite) begin
                unique case (reg_idx)
                    IDX_INTERRUPT_CONTROL: begin
                        s_d.irq_ctrl = wbyte[7:1];
                    end
                    IDX_PERIPHERAL_FLAGS: begin
                        // RULE3 write sets or clears flag
                        s_d.change_flag = wbyte[BIT_CHANGE_FLAG];
                    end
                    IDX_COMPARATOR_CONTROL: begin
                        // RULE19 result bits ignored on write
                        s_d.cmp_ctrl = wbyte[3:0];
                    end
                    IDX_PORT_A_DIRECTION: begin
                        s_d.porta_dir = wbyte[4:0];
                    end
                    IDX_PERIPHERAL_ENABLES: begin
                        s_d.change_irq_enable = wbyte[BIT_CHANGE_IRQ_ENABLE];
                    end
                    IDX_REFERENCE_CONTROL: begin
                        s_d.ref_ctrl = wbyte & MASK_REFERENCE_WR;
                    end
                    IDX_SLEEP_CONTROL: begin
                        s_d.sleeping = wbyte[0];
                    end
                    default: begin
                        s_d.rdata = 32'h0;
                    end
                endcase
            end
        end
        // RULE5 access relatches results
        // RULE8 a change in this cycle is absorbed by the relatch
        if (cmp_access) begin
            s_d.latched = s_q.sync2;
        end
        // RULE6 mismatch keeps setting flag, set wins over clear
        // RULE1 flag set on change
        if (mismatch && !cmp_access) begin
            s_d.change_flag = 1'b1;
        end
        s_d.irq  = irq_cond;
        // RULE9 enabled change wakes core, independent of global enable
        // RULE11 wake clears only sleep control bit 0, not comparator control
        s_d.wake = s_q.sleeping && s_q.change_flag && s_q.change_irq_enable;
        if (s_q.sleeping && s_q.change_flag && s_q.change_irq_enable) begin
            s_d.sleeping = 1'b0;
        end
        // RULE10 mode 111 powers comparators off
        s_d.powered = (s_d.cmp_ctrl[2:0] != CCR_MODE_OFF);
        // RULE18 mode 010 routes internal reference
        s_d.int_ref = (s_d.cmp_ctrl[2:0] == CCR_MODE_INTERNAL);
    end

    // state register
    // RULE12 reset selects mode 000
    // RULE17 reset clears reference control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q                   <= '0;    // comparators powered down
            s_q.irq_ctrl          <= RST_INTERRUPT_CONTROL[7:1];
            s_q.cmp_ctrl          <= RST_COMPARATOR_CONTROL;
            s_q.porta_dir         <= RST_PORT_A_DIRECTION[4:0];
            s_q.ref_ctrl          <= RST_REFERENCE_CONTROL;
        end else begin
            s_q <= s_d;
        end
    end

    // drive ports straight from state flip-flops
    assign prdata                   = s_q.rdata;
    assign pready                   = s_q.ready;
    assign pslverr                  = s_q.slverr;
    assign irq_request              = s_q.irq;
    assign wake_request             = s_q.wake;
    assign comparator_mode_field    = s_q.cmp_ctrl[2:0];
    assign input_switch_select      = s_q.cmp_ctrl[BIT_INPUT_SWITCH];
    assign comparators_powered      = s_q.powered;
    assign internal_ref_to_positive = s_q.int_ref;
    // RULE13 ladder power
    assign reference_power_on       = s_q.ref_ctrl[BIT_REF_POWER_ON];
    assign reference_pin_drive      = s_q.ref_ctrl[BIT_REF_PIN_DRIVE];
    // RULE15 range select steers ladder segment
    assign reference_range_select   = s_q.ref_ctrl[BIT_REF_RANGE];
    // RULE14 tap select picks the level
    assign reference_tap_select     = s_q.ref_ctrl[3:0];
    assign port_a_direction         = s_q.porta_dir;

endmodule

// >>> testbench.sv
/* testbench for ccr_top with an analog model.
   assumes apb answers are awaited, never counted. */
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        res1, res2, ext1, ext2, isel, powered, iref, ref_on, pin_drv, rng, irq, wake;
    logic [2:0]  mode;
    logic [3:0]  tap;
    logic [4:0]  pdir;
    int          ain_mv, error_cnt, check_count;
    ccr_top i_ccr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_comparator_result(res1), .second_comparator_result(res2),
        .comparator_mode_field(mode), .input_switch_select(isel), .comparators_powered(powered),
        .internal_ref_to_positive(iref), .reference_power_on(ref_on),
        .reference_pin_drive(pin_drv), .reference_range_select(rng),
        .reference_tap_select(tap), .port_a_direction(pdir), .irq_request(irq),
        .wake_request(wake));
    ccr_analog_model i_ccr_analog_model (.powered(powered), .internal_ref(iref),
        .ref_on(ref_on), .range_sel(rng), .tap(tap), .ain_mv(ain_mv), .ext1(ext1),
        .ext2(ext2), .res1(res1), .res2(res2));
    // clock
    always #10 pclk = ~pclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b0, 8'h00, rd, err);
        chk(what, {24'h0, exp}, rd);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_reset_values;
        rdc("flags", 12'h030, 8'h00);
        rdc("cmp ctrl", 12'h07c, 8'h00);
        rdc("enables", 12'h230, 8'h00);
        rdc("irq ctrl", 12'h02c, 8'h00);
        rdc("ref ctrl", 12'h27c, 8'h00);
        rdc("port dir", 12'h214, 8'h1f);
        chk("dir pins", 32'h1f, {27'h0, pdir});
        chk("mode", 32'h0, {28'h0, isel, mode});
    endtask
    task automatic t_registers;
        logic [31:0] rd;
        logic err;
        wr(12'h27c, 8'hff);
        rdc("ref ctrl bits", 12'h27c, 8'hef);
        chk("ref outputs", 32'h7f, {25'h0, ref_on, pin_drv, rng, tap});
        wr(12'h07c, 8'hff);
        rdc("cmp ctrl bits", 12'h07c, 8'h0f);
        chk("powered", 32'h0, {31'h0, powered});
        chk("mode off", 32'hf, {28'h0, isel, mode});
        wr(12'h214, 8'hf5);
        rdc("port dir wr", 12'h214, 8'h15);
        chk("dir pins wr", 32'h15, {27'h0, pdir});
        apb(12'h07d, 1'b0, 8'h00, rd, err);
        chk("slverr", 32'h1, {31'h0, err});
        wr(12'h07c, 8'h00);
        wr(12'h27c, 8'h00);
        chk("ref off", 32'h0, {31'h0, ref_on});
    endtask
    task automatic t_change;
        wr(12'h230, 8'h40);
        wr(12'h02c, 8'hc0);
        rdc("irq ctrl set", 12'h02c, 8'hc0);
        ext1 <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("flag set", 12'h030, 8'h40);
        wr(12'h030, 8'h00);
        rdc("flag held", 12'h030, 8'h40);
        rdc("results", 12'h07c, 8'h40);
        wr(12'h030, 8'h00);
        rdc("flag clear", 12'h030, 8'h00);
        ext2 <= 1'b1;
        repeat (5) @(posedge pclk);
        rdc("second", 12'h07c, 8'hc0);
        rdc("flag again", 12'h030, 8'h40);
    endtask
    task automatic t_enables;
        for (int i = 0; i < 8; i++) begin
            wr(12'h230, {1'b0, i[0], 6'h0});
            wr(12'h02c, {i[2], i[1], 6'h0});
            wr(12'h030, 8'h40);
            rdc("flag kept", 12'h030, 8'h40);
            chk("irq gate", {31'h0, i == 7}, {31'h0, irq});
        end
        wr(12'h02c, 8'h00);
        wr(12'h030, 8'h00);
    endtask
    task automatic t_vref;
        wr(12'h07c, 8'h02);
        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 16; t++) begin
                ain_mv <= (r == 1) ? 1000 : 2000;
                wr(12'h27c, {2'b10, r[0], 1'b0, t[3:0]});
                repeat (4) @(posedge pclk);
                rdc("vref compare", 12'h07c, {{2{t >= 5}}, 6'h02});
            end
        end
        wr(12'h27c, 8'h00);
    endtask
    task automatic t_sleep;
        int n;
        wr(12'h07c, 8'h0b);
        repeat (5) @(posedge pclk);
        rdc("mode three", 12'h07c, 8'hcb);
        wr(12'h030, 8'h00);
        wr(12'h300, 8'h01);
        ext1 <= 1'b0;
        n = 0;
        while (wake !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
        chk("wake", 32'h1, {31'h0, wake});
        chk("no irq", 32'h0, {31'h0, irq});
        rdc("after wake", 12'h07c, 8'h8b);
    endtask
    task automatic t_mid_reset;
        ext2 <= 1'b0;
        wr(12'h27c, 8'ha6);
        wr(12'h07c, 8'h02);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("held in reset", 32'h0, {29'h0, powered, irq, wake});
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("ref ctrl reset", 12'h27c, 8'h00);
        rdc("cmp ctrl reset", 12'h07c, 8'h00);
        chk("ref pins reset", 32'h0, {25'h0, ref_on, pin_drv, rng, tap});
        chk("dir reset", 32'h1f, {27'h0, pdir});
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end
    // main sequence
    initial begin
        {pclk, psel, penable, pwrite, paddr, pwdata, ext1, ext2} = '0;
        {ain_mv, error_cnt, check_count} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_registers();
        t_change();
        t_enables();
        t_vref();
        t_sleep();
        t_mid_reset();
        give_verdict();
    end
endmodule
